/* File: rtl/acq_readout.sv */
// Acquisition memory search, view selection and framed memory dump
`timescale 1ns/1ns

// ------------------------------------------------------------
// Reply FIFO
// ------------------------------------------------------------
module reply_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    logic push;
    logic pop;

    // Honest flags straight from the fill count
    assign in_ready = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage has no reset; only the pointers and the fill count need a defined state
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // reply_fifo

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module acq_readout (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Acquisition write port (high-resolution pairs arrive already ordered)
    input wire logic acq_we,
    input wire logic [3:0] acq_data,
    input wire logic acq_armed,
    input wire logic [acq_readout_pkg::SLOT_W-1:0] own_slot,
    // Display and search controls from the front panel logic
    input wire logic [acq_readout_pkg::ADDR_W-1:0] block_base,
    input wire logic search_start,
    input wire acq_readout_pkg::search_req_t search_req,
    input wire logic align_select,
    input wire logic inventory_query,
    // Controller byte stream in
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    // Reply byte stream out
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_byte,
    // Status
    output acq_readout_pkg::search_res_t search_res,
    output logic search_done,
    output logic align_on,
    output acq_readout_pkg::view_t view,
    output logic [7:0] board_code,
    output logic board_valid
);
    import acq_readout_pkg::*;

    logic [3:0] mem [MEM_WORDS];
    logic [ADDR_W-1:0] wr_addr;
    logic wrapped;
    logic [ADDR_W-1:0] sr_addr;
    logic [ADDR_W-1:0] sr_end;
    logic [3:0] sr_pat;
    logic [3:0] rd_word;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] rd_tag;
    logic [ADDR_W-1:0] span;
    srch_t sr_state;
    parse_t p_state;
    logic [2:0] p_idx;
    logic [SLOT_W-1:0] slot_acc;
    logic slot_sel_ok;
    logic query_seen;
    logic dump_go;
    tx_t tx_state;
    logic [2:0] tx_idx;
    logic [ADDR_W:0] tx_left;
    logic [ADDR_W-1:0] tx_addr;
    logic [7:0] sum;
    logic [15:0] byte_count;
    logic f_valid;
    logic f_ready;
    logic [7:0] f_data;
    logic [ADDR_W-1:0] blk;

    // Character of the command name at a position
    function automatic logic [7:0] name_char(input logic [2:0] i);
        name_char = CMD_NAME[8*(NAME_LEN-1-int'(i)) +: 8];
    endfunction

    // Digit test, used while parsing the slot argument
    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= CHAR_ZERO) && (c <= CHAR_NINE);
    endfunction

    // ------------------------------------------------------------
    // Acquisition store
    // ------------------------------------------------------------
    // Channel order is written as captured; the earlier half stays in bits 1 and 3
    always_ff @(posedge mclk) begin
        if (acq_we) begin
            mem[wr_addr] <= acq_data;
        end
    end

    // Write pointer wraps; wrapped marks the whole memory valid
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr <= ADDR_ZERO;
            wrapped <= 1'b0;
        end else if (acq_we) begin
            wr_addr <= wr_addr + ADDR_W'(1);
            if (wr_addr == ADDR_W'(MEM_WORDS - 1)) begin
                wrapped <= 1'b1;
            end
        end
    end

    // One shared read port: dump has priority over search when both are active
    // The tag records which address rd_word belongs to, so a stale word is never sent
    assign rd_addr = (tx_state == TX_DATA) ? tx_addr : sr_addr;
    always_ff @(posedge mclk) begin
        rd_word <= mem[rd_addr];
        rd_tag <= rd_addr;
    end

    // ------------------------------------------------------------
    // View alignment
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            align_on <= 1'b1;
        end else if (align_select) begin
            align_on <= !align_on;
        end
    end

    // Aligned view only makes sense for an armed capture; else everything valid
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            view <= '0;
        end else if (acq_armed && align_on) begin
            view.first <= wr_addr - ADDR_W'(BLOCK_WORDS);
            view.last <= wr_addr - ADDR_W'(1);
        end else begin
            view.first <= wrapped ? wr_addr : ADDR_ZERO;
            view.last <= wr_addr - ADDR_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Pattern search
    // ------------------------------------------------------------
    // Block base snaps to a 512-word boundary so a scan cannot spill out
    assign blk = block_base & BLOCK_MASK;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sr_state <= SR_IDLE;
            sr_addr <= ADDR_ZERO;
            sr_end <= ADDR_ZERO;
            sr_pat <= 4'h0;
            search_res <= '0;
            search_done <= 1'b0;
        end else begin
            search_done <= 1'b0;
            unique case (sr_state)
                SR_IDLE: begin
                    if (search_start) begin
                        sr_pat <= search_req.pattern;
                        sr_end <= blk | BLOCK_LAST;
                        if (search_req.cursor <= HALF_LAST) begin
                            sr_addr <= blk;
                        end else begin
                            sr_addr <= blk | (search_req.cursor & BLOCK_LAST);
                        end
                        search_res.cursor <= search_req.cursor;
                        search_res.found <= 1'b0;
                        sr_state <= SR_READ;
                    end
                end
                SR_READ: begin
                    // Read port is busy during a dump; wait it out
                    if (tx_state != TX_DATA) begin
                        sr_state <= SR_CHECK;
                    end
                end
                SR_CHECK: begin
                    if (rd_word == sr_pat) begin
                        search_res.found <= 1'b1;
                        search_res.cursor <= sr_addr;
                        search_done <= 1'b1;
                        sr_state <= SR_IDLE;
                    end else if (sr_addr == sr_end) begin
                        search_done <= 1'b1;
                        sr_state <= SR_IDLE;
                    end else begin
                        sr_addr <= sr_addr + ADDR_W'(1);
                        sr_state <= SR_READ;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command parser
    // ------------------------------------------------------------
    // Name, then either '?' (query) or space and decimal slot ended by any non-digit byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p_state <= PARSE_IDLE;
            p_idx <= 3'h0;
            slot_acc <= '0;
            slot_sel_ok <= 1'b0;
            query_seen <= 1'b0;
        end else begin
            query_seen <= 1'b0;
            if (rx_valid) begin
                unique case (p_state)
                    PARSE_IDLE: begin
                        if (rx_byte == name_char(3'h0)) begin
                            p_idx <= 3'h1;
                            p_state <= PARSE_NAME;
                        end
                    end
                    PARSE_NAME: begin
                        if (int'(p_idx) == NAME_LEN) begin
                            if (rx_byte == CHAR_QUERY) begin
                                query_seen <= slot_sel_ok;
                                p_state <= PARSE_IDLE;
                            end else if (rx_byte == CHAR_SPACE) begin
                                slot_acc <= '0;
                                p_state <= PARSE_ARG;
                            end else begin
                                p_state <= PARSE_IDLE;
                            end
                        end else if (rx_byte == name_char(p_idx)) begin
                            p_idx <= p_idx + 3'h1;
                        end else begin
                            p_state <= PARSE_IDLE;
                        end
                    end
                    PARSE_ARG: begin
                        if (is_digit(rx_byte)) begin
                            slot_acc <= SLOT_W'(slot_acc * 4'hA) + SLOT_W'(rx_byte - CHAR_ZERO);
                        end else begin
                            slot_sel_ok <= (slot_acc == own_slot);
                            p_state <= PARSE_IDLE;
                        end
                    end
                    default: p_state <= PARSE_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Reply framer, feeding the FIFO
    // ------------------------------------------------------------
    // The dump covers the current view, so OFF sends all valid memory
    // Span is taken at address width so a wrapped view still counts correctly
    assign span = view.last - view.first;
    assign byte_count = 16'(span) + 16'h0001;
    assign dump_go = query_seen && (tx_state == TX_IDLE);

    always_comb begin
        f_valid = 1'b0;
        f_data = 8'h00;
        unique case (tx_state)
            TX_IDLE: f_valid = 1'b0;
            TX_NAME: begin
                f_valid = 1'b1;
                f_data = name_char(tx_idx);
            end
            TX_PCT: begin
                f_valid = 1'b1;
                f_data = CHAR_PERCENT;
            end
            TX_CNT_HI: begin
                f_valid = 1'b1;
                f_data = byte_count[15:8];
            end
            TX_CNT_LO: begin
                f_valid = 1'b1;
                f_data = byte_count[7:0];
            end
            TX_DATA: begin
                // Registered read: offer the byte only once it matches the address
                f_valid = (rd_tag == tx_addr);
                f_data = {4'h0, rd_word};
            end
            TX_SUM: begin
                f_valid = 1'b1;
                f_data = 8'h00 - sum;
            end
            TX_SEMI: begin
                f_valid = 1'b1;
                f_data = CHAR_SEMI;
            end
        endcase
    end

    // Sequencing; a byte advances only when the FIFO takes it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            tx_idx <= 3'h0;
            tx_left <= '0;
            tx_addr <= ADDR_ZERO;
            sum <= 8'h00;
        end else if (dump_go) begin
            tx_state <= TX_NAME;
            tx_idx <= 3'h0;
            sum <= 8'h00;
        end else if (f_valid && f_ready) begin
            unique case (tx_state)
                TX_NAME: begin
                    tx_idx <= tx_idx + 3'h1;
                    if (int'(tx_idx) == NAME_LEN - 1) begin
                        tx_state <= TX_PCT;
                    end
                end
                TX_PCT: tx_state <= TX_CNT_HI;
                TX_CNT_HI: begin
                    sum <= sum + f_data;
                    tx_state <= TX_CNT_LO;
                end
                TX_CNT_LO: begin
                    sum <= sum + f_data;
                    tx_left <= byte_count[ADDR_W:0];
                    tx_addr <= view.first;
                    tx_state <= TX_DATA;
                end
                TX_DATA: begin
                    sum <= sum + f_data;
                    tx_addr <= tx_addr + ADDR_W'(1);
                    tx_left <= tx_left - (ADDR_W+1)'(1);
                    if (tx_left == (ADDR_W+1)'(1)) begin
                        tx_state <= TX_SUM;
                    end
                end
                TX_SUM: tx_state <= TX_SEMI;
                TX_SEMI: tx_state <= TX_IDLE;
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    reply_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .in_data(f_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_byte)
    );

    // ------------------------------------------------------------
    // Board inventory
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            board_code <= 8'h00;
            board_valid <= 1'b0;
        end else begin
            board_valid <= inventory_query;
            if (inventory_query) begin
                board_code <= BOARD_TYPE;
            end
        end
    end
endmodule // acq_readout

/* File: rtl/acq_readout_pkg.sv */
// Package: constants, types and framing values for the acquisition readout block
package acq_readout_pkg;
    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int MEM_WORDS = 2048;
    localparam int ADDR_W = 11;
    localparam int BLOCK_WORDS = 512;
    localparam int HALF_WORDS = 256;
    localparam logic [ADDR_W-1:0] BLOCK_LAST = 11'h1FF;
    localparam logic [ADDR_W-1:0] HALF_LAST = 11'h0FF;
    localparam logic [ADDR_W-1:0] BLOCK_MASK = 11'h600;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
    localparam int SLOT_W = 4;

    // ------------------------------------------------------------
    // Command and reply framing characters
    // ------------------------------------------------------------
    localparam int NAME_LEN = 6;
    localparam logic [7:0] CHAR_PERCENT = 8'h25;
    localparam logic [7:0] CHAR_SEMI = 8'h3B;
    localparam logic [7:0] CHAR_SPACE = 8'h20;
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_NINE = 8'h39;
    localparam logic [7:0] CHAR_QUERY = 8'h3F;
    localparam logic [7:0] CHAR_LF = 8'h0A;
    // Name characters sent as the reply header (and matched on input)
    localparam logic [8*NAME_LEN-1:0] CMD_NAME = 48'h4143514D454D;

    // Board type code; value is arbitrary
    localparam logic [7:0] BOARD_TYPE = 8'h5A;

    // ------------------------------------------------------------
    // FIFO in the reply path
    // ------------------------------------------------------------
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 32;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] pattern;
        logic [ADDR_W-1:0] cursor;
    } search_req_t;

    typedef struct packed {
        logic found;
        logic [ADDR_W-1:0] cursor;
    } search_res_t;

    typedef struct packed {
        logic [ADDR_W-1:0] first;
        logic [ADDR_W-1:0] last;
    } view_t;

    typedef enum logic [1:0] {PARSE_IDLE, PARSE_NAME, PARSE_ARG} parse_t;
    typedef enum logic [2:0] {TX_IDLE, TX_NAME, TX_PCT, TX_CNT_HI, TX_CNT_LO, TX_DATA, TX_SUM, TX_SEMI} tx_t;
    typedef enum logic [1:0] {SR_IDLE, SR_READ, SR_CHECK} srch_t;
endpackage

/* File: tb/acq_readout_props.sv */
// Checker: concurrent properties on the acquisition readout ports
`timescale 1ns/1ns
module acq_readout_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Search and view
    input wire logic [acq_readout_pkg::ADDR_W-1:0] block_base,
    input wire logic search_start,
    input wire acq_readout_pkg::search_req_t search_req,
    input wire logic search_done,
    input wire acq_readout_pkg::search_res_t search_res,
    input wire logic align_select,
    input wire logic align_on,
    input wire logic acq_armed,
    input wire acq_readout_pkg::view_t view,
    // Inventory
    input wire logic inventory_query,
    input wire logic board_valid,
    input wire logic [7:0] board_code,
    // Byte streams
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_byte
);
    import acq_readout_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Request is held from its start so the result can be judged against it
    search_req_t req;
    logic q_seen;
    logic [ADDR_W-1:0] blk;
    logic [ADDR_W-1:0] start;
    assign blk = block_base & BLOCK_MASK;
    assign start = (req.cursor <= HALF_LAST) ? blk : (blk | (req.cursor & BLOCK_LAST));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) req <= '0;
        else if (search_start) req <= search_req;
    end
    // A reply may not appear before any query byte arrived
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) q_seen <= 1'b0;
        else if (rx_valid && rx_byte == CHAR_QUERY) q_seen <= 1'b1;
    end
    property p_board; inventory_query |=> board_valid && board_code == BOARD_TYPE; endproperty
    a_board: assert property (p_board) else $error("board code not answered");
    property p_align; align_select |=> align_on != $past(align_on); endproperty
    a_align: assert property (p_align) else $error("alignment did not step");
    property p_bound; search_done && search_res.found |-> (search_res.cursor & BLOCK_MASK) == blk; endproperty
    a_bound: assert property (p_bound) else $error("match outside display block");
    property p_start; search_done && search_res.found |-> search_res.cursor >= start; endproperty
    a_start: assert property (p_start) else $error("match before scan start");
    property p_miss; search_done && !search_res.found |-> search_res.cursor == req.cursor; endproperty
    a_miss: assert property (p_miss) else $error("cursor moved without match");
    property p_view;
        align_on && acq_armed && $past(align_on) && $past(acq_armed) |-> view.last - view.first == BLOCK_LAST;
    endproperty
    a_view: assert property (p_view) else $error("aligned view not 512 words");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
    a_hold: assert property (p_hold) else $error("reply byte lost while stalled");
    property p_quiet; !q_seen |-> !tx_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("reply without query");
    c_found: cover property (search_done && search_res.found);
    c_end: cover property (tx_valid && tx_ready && tx_byte == CHAR_SEMI);
    c_stall: cover property (tx_valid && !tx_ready);
endmodule // acq_readout_props
bind acq_readout acq_readout_props u_props (.mclk, .rst_n, .block_base, .search_start, .search_req,
    .search_done, .search_res, .align_select, .align_on, .acq_armed, .view, .inventory_query,
    .board_valid, .board_code, .rx_valid, .rx_byte, .tx_valid, .tx_ready, .tx_byte);

/* File: tb/gpib_ctrl_model.sv */
// Controller model: sends command text and collects the framed reply
`timescale 1ns/1ns
module gpib_ctrl_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Command bytes to the block
    output logic rx_valid,
    output logic [7:0] rx_byte,
    // Reply bytes from the block
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_byte
);
    logic [7:0] got [$];
    logic stall = 1'b0;
    int phase = 0;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end
    // One byte per cycle; the line is inverted after so no stale byte remains
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge mclk);
            #1;
            rx_valid = 1'b1;
            rx_byte = s[i];
        end
        @(posedge mclk);
        #1;
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
    endtask
    // Stalled drain takes one byte in three, which lets the FIFO fill
    always @(posedge mclk) begin
        if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_byte);
        phase = (phase + 1) % 3;
        #1 tx_ready = rst_n && (!stall || phase == 0);
    end
    // Every byte after the percent sign up to and including the checksum sums to zero
    function automatic logic sum_ok(input int from, input int upto);
        logic [7:0] s;
        s = 8'h00;
        for (int i = from; i <= upto; i++) s += got[i];
        return s == 8'h00;
    endfunction
    // Rebuilds one fast channel pair, earlier bit on the left
    function automatic logic [1:0] chan_pair(input logic [3:0] w, input logic hi);
        return hi ? {w[3], w[2]} : {w[1], w[0]};
    endfunction
endmodule // gpib_ctrl_model

/* File: tb/testbench.sv */
// Testbench: search, view, inventory and memory dump scenarios
`timescale 1ns/1ns
module testbench;
    import acq_readout_pkg::*;
    // ----------------------------------------
    // Stimulus, responses and bookkeeping
    // ----------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic acq_we = 1'b0;
    logic [3:0] acq_data = 4'h0;
    logic acq_armed = 1'b0;
    logic [SLOT_W-1:0] own_slot = 4'h3;
    logic [ADDR_W-1:0] block_base = 11'h200;
    logic search_start = 1'b0;
    search_req_t search_req = '0;
    logic align_select = 1'b0;
    logic inventory_query = 1'b0;
    logic rx_valid, tx_valid, tx_ready, search_done, align_on, board_valid;
    logic [7:0] rx_byte, tx_byte, board_code;
    search_res_t search_res;
    view_t view;
    logic [3:0] mem [0:1023];
    int err_count = 0;
    int checked = 0;
    always #4 mclk = ~mclk;
    acq_readout dut (.mclk, .rst_n, .acq_we, .acq_data, .acq_armed, .own_slot, .block_base, .search_start,
        .search_req, .align_select, .inventory_query, .rx_valid, .rx_byte, .tx_valid, .tx_ready, .tx_byte,
        .search_res, .search_done, .align_on, .view, .board_code, .board_valid);
    gpib_ctrl_model ctl (.mclk, .rst_n, .rx_valid, .rx_byte, .tx_valid, .tx_ready, .tx_byte);
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic t_board();
        inventory_query = 1'b1;
        tick();
        inventory_query = 1'b0;
        chk("board_valid", 16'(board_valid), 16'h1);
        chk("board_code", 16'(board_code), 16'(BOARD_TYPE));
    endtask
    // Words repeat modulo 13, so pattern values 13..15 never occur
    task automatic t_fill();
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 4'(i % 13);
            acq_we = 1'b1;
            acq_data = mem[i];
            tick();
        end
        acq_we = 1'b0;
    endtask
    task automatic t_search(input logic [10:0] base, input logic [10:0] cur, input logic [3:0] pat);
        logic [10:0] a;
        logic [10:0] exp;
        logic hit;
        a = (cur <= HALF_LAST) ? base : (base | (cur & BLOCK_LAST));
        hit = 1'b0;
        exp = cur;
        for (int i = int'(a); i <= int'(base | BLOCK_LAST); i++) begin
            if (!hit && mem[i] == pat) begin
                hit = 1'b1;
                exp = 11'(i);
            end
        end
        block_base = base;
        search_req = '{pattern: pat, cursor: cur};
        search_start = 1'b1;
        tick();
        search_start = 1'b0;
        for (int n = 0; n < 1300 && search_done !== 1'b1; n++) tick();
        chk("search_done", 16'(search_done), 16'h1);
        chk("search_found", 16'(search_res.found), 16'(hit));
        chk("search_cursor", 16'(search_res.cursor), 16'(exp));
    endtask
    // OFF shows all written words; ON with arming keeps the last 512
    task automatic t_align();
        align_select = 1'b1;
        tick();
        align_select = 1'b0;
        chk("align_off", 16'(align_on), 16'h0);
        tick();
        chk("view_all_first", 16'(view.first), 16'h0);
        chk("view_all_last", 16'(view.last), 16'd1023);
        align_select = 1'b1;
        tick();
        align_select = 1'b0;
        chk("align_on", 16'(align_on), 16'h1);
        acq_armed = 1'b1;
        repeat (2) tick();
        chk("view_aligned_first", 16'(view.first), 16'd512);
        chk("view_aligned_last", 16'(view.last), 16'd1023);
    endtask
    // Wrong slot is refused, then the right slot yields a full frame under stall
    task automatic t_dump();
        logic [7:0] s;
        string nm;
        nm = $sformatf("%s", CMD_NAME);
        ctl.stall = 1'b1;
        ctl.send({nm, " 5\n"});
        ctl.send({nm, "?"});
        repeat (40) tick();
        chk("refused_len", 16'(ctl.got.size()), 16'h0);
        ctl.send({nm, " 3\n"});
        ctl.send({nm, "?"});
        for (int n = 0; n < 4000 && ctl.got.size() < 523; n++) tick();
        repeat (20) tick();
        chk("reply_len", 16'(ctl.got.size()), 16'd523);
        if (ctl.got.size() != 523) return;
        for (int i = 0; i < NAME_LEN; i++) chk("name", 16'(ctl.got[i]), 16'(CMD_NAME[47-8*i -: 8]));
        chk("percent", 16'(ctl.got[6]), 16'(CHAR_PERCENT));
        chk("count_hi", 16'(ctl.got[7]), 16'h02);
        chk("count_lo", 16'(ctl.got[8]), 16'h00);
        s = ctl.got[7] + ctl.got[8];
        for (int i = 0; i < 512; i++) begin
            chk("data", 16'(ctl.got[9+i] & 8'h0F), 16'(mem[512+i]));
            s += ctl.got[9+i];
        end
        chk("pair_lo", 16'(ctl.chan_pair(4'(ctl.got[9]), 1'b0)), 16'({mem[512][1], mem[512][0]}));
        chk("checksum", 16'(ctl.got[521]), 16'(8'(-s)));
        chk("sum_zero", 16'(ctl.sum_ok(7, 521)), 16'h1);
        chk("terminator", 16'(ctl.got[522]), 16'(CHAR_SEMI));
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        tick();
        chk("align_reset", 16'(align_on), 16'h1);
        chk("tx_idle", 16'(tx_valid), 16'h0);
        t_board();
        t_fill();
        t_search(11'h200, 11'h0FF, 4'h5);
        t_search(11'h200, 11'h100, 4'h5);
        t_search(11'h200, 11'h3FC, 4'hC);
        t_search(11'h200, 11'h010, 4'hF);
        t_search(11'h000, 11'h300, 4'h5);
        t_align();
        t_dump();
        end_of_test();
    end
    // Watchdog: the run needs about 3,800 cycles, so 25,000 means a hang
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
endmodule // testbench
